// File: src/tgc_pkg.sv
// constants shared by the gate timing core and its synchroniser
package tgc_pkg;

  // time base
  localparam int CLK_MHZ = 125;

  // serial frame: command in the top nibble, data below
  localparam int WORD_W = 16;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int DATA_W = 12;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_DEADTIME = 4'h1;
  localparam logic [3:0] CMD_ZERO_DT = 4'h2;
  localparam logic [3:0] CMD_MODE = 4'h3;
  localparam logic [3:0] CMD_CLEAR = 4'h4;
  localparam int MODE_FULL_BIT = 0;

  // deadtime in time-base cycles
  localparam int DT_W = 8;
  localparam logic [DT_W-1:0] DT_MIN = 8'h01;
  localparam logic [DT_W-1:0] DT_MAX = 8'hff;
  localparam logic [DT_W-1:0] DT_RESET = 8'h10;
  localparam logic [DATA_W-1:0] DT_DATA_MAX = 12'h0ff;

  // spi clock ceiling, for reference by the bench
  localparam int SPI_FMAX_KHZ = 4000;

  // blanking window, longest figure so rounded down
  localparam int BLANK_NS = 7100;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ) / 1000;
  localparam int BLANK_W = $clog2(BLANK_CYC + 1);

  // desaturation filter, a least time so rounded up
  localparam int DESAT_FILT_NS = 937;
  localparam int DESAT_FILT_CYC = (DESAT_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int DESAT_W = $clog2(DESAT_FILT_CYC + 1);

  // overtemperature filter
  localparam int OT_FILT_NS = 1000;
  localparam int OT_FILT_CYC = (OT_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int OT_W = $clog2(OT_FILT_CYC + 1);

  // status word layout shifted out on so
  localparam int ST_FULL = 15;
  localparam int ST_ZERO_DT = 14;
  localparam int ST_OT = 13;
  localparam int ST_DESAT_LSB = 10;
  localparam int ST_PHASE_LSB = 7;

  // pin bundle layout at the synchroniser
  localparam int PIN_W = 14;
  localparam logic [PIN_W-1:0] PIN_INIT = 14'h2000;

endpackage

// File: src/tgc_sync.sv
// three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/10ps
module tgc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] agreed;
  } tgc_sync_t;

  tgc_sync_t q;
  tgc_sync_t next_q;

  always_comb begin
    next_q = q;
    next_q.s1 = din;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    // only bits that held for two stages pass; s1 feeds nothing else
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.agreed[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= {INIT, INIT, INIT, INIT};
    end else begin
      q <= next_q;
    end
  end

  assign dout = q.agreed;

endmodule

// File: src/tgc_core.sv
// three-phase gate timing core: deadtime, blanking, fault filters, spi setup
//
// Behaviour
// - deadtime command sets a delay of 1 to 255 time-base cycles.
// - deadtime requests above 255 saturate at 255.
// - a separate command selects zero deadtime, no inserted delay.
// - core logic runs on one clock; pin inputs are synchronised first.
// - normal path: one cycle decision stage, one cycle output mux stage.
// - full-conduct mode bypasses the decision stage, one cycle shorter.
// - synchronisation latency varies by at most one cycle.
// - any output turn-on starts blanking of desat and phase errors.
// - overtemperature input is filtered before raising the warning.
// - outputs may stay off or on indefinitely; no on-time limit.
// - serial clock up to 4 MHz must work; master runs at 6.25 MHz, above it.
// - serial output driven only while chip select is low; so_oe here lags select and stays on up to five cycles after it rises.
// - serial output changes after each rising serial clock edge.
// - serial input sampled on the falling serial clock edge.
// - deadtime count starts at turn-off and blocks the complement.
// - desat fault reported only after persisting the filter interval.
// - blanking window lasts a fixed several microseconds, about seven.
`timescale 1ns/10ps
module tgc_core (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic [2:0] hs_in,
  input wire logic [2:0] ls_in,
  input wire logic [2:0] desat_in,
  input wire logic [2:0] phase_err_in,
  input wire logic overtemp_in,
  output logic [2:0] hs_gate,
  output logic [2:0] ls_gate,
  output logic [2:0] desat_fault,
  output logic [2:0] phase_fault,
  output logic overtemp_warn,
  output logic blank_active,
  output logic full_conduct_mode,
  output logic zero_deadtime,
  output logic [tgc_pkg::DT_W-1:0] deadtime
);

  // ---------------- serial side, on the link clock ----------------

  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [tgc_pkg::WORD_W-2:0] shift;
  } tgc_rx_t;

  typedef struct packed {
    logic [tgc_pkg::WORD_W-1:0] word;
    logic toggle;
  } tgc_cmd_t;

  typedef struct packed {
    logic [3:0] tx_cnt;
    logic so;
  } tgc_tx_t;

  tgc_rx_t rx;
  tgc_rx_t next_rx;
  tgc_cmd_t cmd;
  tgc_cmd_t next_cmd;
  tgc_tx_t tx;
  tgc_tx_t next_tx;
  logic frame_rst;
  logic [tgc_pkg::WORD_W-1:0] status_word;

  // select high clears the frame logic, so a clock that stops
  // between frames leaves nothing half done
  assign frame_rst = ~reset_n | cs_n;

  always_comb begin
    next_rx = rx;
    next_cmd = cmd;
    next_rx.bit_cnt = rx.bit_cnt + 4'h1;
    next_rx.shift = {rx.shift[tgc_pkg::WORD_W-3:0], si};
    // a short frame never reaches the last bit and is dropped
    if (rx.bit_cnt == tgc_pkg::BIT_LAST) begin
      next_cmd.word = {rx.shift, si};
      next_cmd.toggle = ~cmd.toggle;
    end
  end

  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // the received word stays put until the next full frame
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd <= '0;
    end else begin
      cmd <= next_cmd;
    end
  end

  always_comb begin
    next_tx = tx;
    next_tx.tx_cnt = tx.tx_cnt + 4'h1;
    // status_word is frozen while select is low, so reading it
    // here across domains is safe
    next_tx.so = status_word[tgc_pkg::BIT_LAST - tx.tx_cnt];
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end

  assign so = tx.so;

  // ---------------- time-base side ----------------

  logic [tgc_pkg::PIN_W-1:0] pins_s;
  logic tog_s;
  logic [2:0] hs_s;
  logic [2:0] ls_s;
  logic [2:0] desat_s;
  logic [2:0] phase_s;
  logic ot_s;
  logic cs_s;

  tgc_sync #(
    .WIDTH(tgc_pkg::PIN_W),
    .INIT(tgc_pkg::PIN_INIT)
  ) u_pin_sync (
    .clk(core_clk),
    .reset_n(reset_n),
    .din({cs_n, overtemp_in, phase_err_in, desat_in, ls_in, hs_in}),
    .dout(pins_s)
  );

  // the frame toggle crosses as a level; its change marks a command
  tgc_sync #(
    .WIDTH(1),
    .INIT(1'b0)
  ) u_cmd_sync (
    .clk(core_clk),
    .reset_n(reset_n),
    .din(cmd.toggle),
    .dout(tog_s)
  );

  assign hs_s = pins_s[2:0];
  assign ls_s = pins_s[5:3];
  assign desat_s = pins_s[8:6];
  assign phase_s = pins_s[11:9];
  assign ot_s = pins_s[12];
  assign cs_s = pins_s[13];

  typedef struct packed {
    logic [2:0] dec_hs;
    logic [2:0] dec_ls;
    logic [2:0] req_hs;
    logic [2:0] req_ls;
    logic [2:0][tgc_pkg::DT_W-1:0] dt_cnt;
    logic [2:0] hs_gate;
    logic [2:0] ls_gate;
    logic [tgc_pkg::BLANK_W-1:0] blank_cnt;
    logic blank_active;
    logic [2:0][tgc_pkg::DESAT_W-1:0] desat_cnt;
    logic [2:0] desat_fault;
    logic [2:0] phase_fault;
    logic [tgc_pkg::OT_W-1:0] ot_cnt;
    logic ot_warn;
    logic [tgc_pkg::DT_W-1:0] deadtime;
    logic zero_dt;
    logic full_conduct;
    logic tog;
    logic so_oe;
    logic [tgc_pkg::WORD_W-1:0] status;
  } tgc_core_t;

  localparam logic [tgc_pkg::BLANK_W-1:0] BLANK_LOAD =
    tgc_pkg::BLANK_W'(tgc_pkg::BLANK_CYC);
  localparam logic [tgc_pkg::DESAT_W-1:0] DESAT_LAST =
    tgc_pkg::DESAT_W'(tgc_pkg::DESAT_FILT_CYC - 1);
  localparam logic [tgc_pkg::OT_W-1:0] OT_FULL =
    tgc_pkg::OT_W'(tgc_pkg::OT_FILT_CYC);

  tgc_core_t q;
  tgc_core_t next_q;

  logic cmd_evt;
  logic clr;
  logic [3:0] cmd_code;
  logic [tgc_pkg::DATA_W-1:0] cmd_data;

  assign cmd_evt = tog_s ^ q.tog;
  assign cmd_code = cmd.word[tgc_pkg::CMD_MSB:tgc_pkg::CMD_LSB];
  assign cmd_data = cmd.word[tgc_pkg::DATA_W-1:0];

  always_comb begin
    logic fall;
    logic allow;
    logic turn_on;
    logic d_set;
    logic p_set;
    fall = 1'b0;
    allow = 1'b0;
    turn_on = 1'b0;
    d_set = 1'b0;
    p_set = 1'b0;
    next_q = q;
    clr = 1'b0;
    next_q.tog = tog_s;

    // command decode; the word is stable long before the toggle lands
    if (cmd_evt) begin
      case (cmd_code)
        tgc_pkg::CMD_DEADTIME: begin
          next_q.zero_dt = 1'b0;
          if (cmd_data == '0) begin
            next_q.deadtime = tgc_pkg::DT_MIN;
          end else if (cmd_data > tgc_pkg::DT_DATA_MAX) begin
            next_q.deadtime = tgc_pkg::DT_MAX;
          end else begin
            next_q.deadtime = cmd_data[tgc_pkg::DT_W-1:0];
          end
        end
        tgc_pkg::CMD_ZERO_DT: begin
          next_q.zero_dt = 1'b1;
        end
        tgc_pkg::CMD_MODE: begin
          next_q.full_conduct = cmd.word[tgc_pkg::MODE_FULL_BIT];
        end
        tgc_pkg::CMD_CLEAR: begin
          clr = 1'b1;
        end
        default: begin
        end
      endcase
    end

    for (int i = 0; i < 3; i++) begin
      next_q.req_hs[i] = hs_s[i];
      next_q.req_ls[i] = ls_s[i];
      // any request dropping is a turn-off command
      fall = (q.req_hs[i] & ~hs_s[i]) | (q.req_ls[i] & ~ls_s[i]);
      if (fall && !q.zero_dt) begin
        next_q.dt_cnt[i] = q.deadtime;
      end else if (q.dt_cnt[i] != '0) begin
        next_q.dt_cnt[i] = q.dt_cnt[i] - 1'b1;
      end
      // zero deadtime never loads the count, so turn-on is direct
      allow = (q.dt_cnt[i] == '0) & ~(fall & ~q.zero_dt);
      // decision stage; both requests high keeps both sides off
      next_q.dec_hs[i] = hs_s[i] & ~ls_s[i] & allow;
      next_q.dec_ls[i] = ls_s[i] & ~hs_s[i] & allow;
      // a held request keeps its output on with no time limit
      if (q.full_conduct) begin
        next_q.hs_gate[i] = hs_s[i];
        next_q.ls_gate[i] = ls_s[i];
      end else begin
        next_q.hs_gate[i] = q.dec_hs[i];
        next_q.ls_gate[i] = q.dec_ls[i];
      end

      // desat must hold unblanked for the whole filter interval
      if (desat_s[i] && !q.blank_active) begin
        if (q.desat_cnt[i] != DESAT_LAST) begin
          next_q.desat_cnt[i] = q.desat_cnt[i] + 1'b1;
        end
        d_set = (q.desat_cnt[i] == DESAT_LAST);
      end else begin
        next_q.desat_cnt[i] = '0;
        d_set = 1'b0;
      end
      p_set = phase_s[i] & ~q.blank_active;
      // a fault arriving with the clear command survives it
      if (d_set) begin
        next_q.desat_fault[i] = 1'b1;
      end else if (clr) begin
        next_q.desat_fault[i] = 1'b0;
      end
      if (p_set) begin
        next_q.phase_fault[i] = 1'b1;
      end else if (clr) begin
        next_q.phase_fault[i] = 1'b0;
      end
    end

    // one window shared by all three phases
    turn_on = |((next_q.hs_gate & ~q.hs_gate) |
                (next_q.ls_gate & ~q.ls_gate));
    if (turn_on) begin
      next_q.blank_cnt = BLANK_LOAD;
    end else if (q.blank_cnt != '0) begin
      next_q.blank_cnt = q.blank_cnt - 1'b1;
    end
    next_q.blank_active = (next_q.blank_cnt != '0);

    // overtemp warning only after the input held a full filter time
    if (ot_s) begin
      if (q.ot_cnt != OT_FULL) begin
        next_q.ot_cnt = q.ot_cnt + 1'b1;
      end
    end else begin
      next_q.ot_cnt = '0;
    end
    next_q.ot_warn = (next_q.ot_cnt == OT_FULL);

    // enable lags select by the sync depth, well inside a frame lead
    next_q.so_oe = ~cs_s;

    // status frozen during a frame so the link side reads it steadily
    if (cs_s) begin
      next_q.status = '0;
      next_q.status[tgc_pkg::ST_FULL] = next_q.full_conduct;
      next_q.status[tgc_pkg::ST_ZERO_DT] = next_q.zero_dt;
      next_q.status[tgc_pkg::ST_OT] = next_q.ot_warn;
      next_q.status[tgc_pkg::ST_DESAT_LSB +: 3] = next_q.desat_fault;
      next_q.status[tgc_pkg::ST_PHASE_LSB +: 3] = next_q.phase_fault;
      next_q.status[tgc_pkg::DT_W-2:0] =
        next_q.deadtime[tgc_pkg::DT_W-2:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.deadtime <= tgc_pkg::DT_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign status_word = q.status;
  assign so_oe = q.so_oe;
  assign hs_gate = q.hs_gate;
  assign ls_gate = q.ls_gate;
  assign desat_fault = q.desat_fault;
  assign phase_fault = q.phase_fault;
  assign overtemp_warn = q.ot_warn;
  assign blank_active = q.blank_active;
  assign full_conduct_mode = q.full_conduct;
  assign zero_deadtime = q.zero_dt;
  assign deadtime = q.deadtime;

endmodule

// File: tb/tgc_checker.sv
// port assertions for the gate timing core
`timescale 1ns/10ps
module tgc_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [2:0] hs_gate,
  input wire logic [2:0] ls_gate,
  input wire logic [2:0] desat_in,
  input wire logic overtemp_in,
  input wire logic [2:0] desat_fault,
  input wire logic overtemp_warn,
  input wire logic blank_active,
  input wire logic full_conduct_mode,
  input wire logic [7:0] deadtime
);
  // raw high-run counters; sync delay only makes them larger
  int dhi;
  int ohi;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dhi <= 0;
      ohi <= 0;
    end else begin
      dhi <= desat_in[0] ? dhi + 1 : 0;
      ohi <= overtemp_in ? ohi + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  AST_DT_NZ: assert property (deadtime != 8'h00)
    else $error("deadtime zero");
  AST_NO_SHOOT: assert property (!full_conduct_mode &&
    !$past(full_conduct_mode) |-> (hs_gate & ls_gate) == 3'h0)
    else $error("both sides on");
  AST_SO_IDLE: assert property (cs_n |-> so == 1'b0)
    else $error("so active while deselected");
  AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:8] so_oe)
    else $error("so not enabled");
  AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
    else $error("so not released");
  AST_BLANK: assert property (|((hs_gate & ~$past(hs_gate)) |
    (ls_gate & ~$past(ls_gate))) |=> blank_active)
    else $error("turn-on without blanking");
  AST_DESAT_BL: assert property (|(desat_fault &
    ~$past(desat_fault)) |-> !$past(blank_active))
    else $error("desat fault while blanked");
  AST_DESAT_FILT: assert property ($rose(desat_fault[0]) |->
    dhi >= tgc_pkg::DESAT_FILT_CYC)
    else $error("desat fault too early");
  AST_OT_FILT: assert property ($rose(overtemp_warn) |->
    ohi >= tgc_pkg::OT_FILT_CYC)
    else $error("overtemp warn too early");
endmodule

bind tgc_core tgc_checker i_chk (.core_clk, .reset_n, .cs_n, .so, .so_oe,
  .hs_gate, .ls_gate, .desat_in, .overtemp_in, .desat_fault,
  .overtemp_warn, .blank_active, .full_conduct_mode, .deadtime);

// File: tb/tgc_spi_master.sv
// spi master model that sends one 16-bit frame per call
`timescale 1ns/10ps
module tgc_spi_master (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic xfer(input logic [15:0] wd, output logic [15:0] rd);
    #3;
    cs_n = 1'b0;
    #120;
    for (int i = 15; i >= 0; i--) begin
      si = wd[i];
      #40;
      sclk = 1'b1;
      #80;
      rd[i] = so;
      sclk = 1'b0;
      #40;
    end
    #80;
    cs_n = 1'b1;
    // undriven line must not keep its last bit
    si = ~si;
    #240;
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the gate timing core
`timescale 1ns/10ps
module tb_top;
  logic core_clk, reset_n, sclk, cs_n, si, so, so_oe, ot, ow, ba, fm, zd;
  logic [2:0] hs, ls, ds, pe, hg, lg, df, pf;
  logic [7:0] dt;
  logic [15:0] rx;
  int n_errors, n_tests, n, g, cn, cf;
  tgc_core i_dut (.core_clk(core_clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .hs_in(hs), .ls_in(ls),
    .desat_in(ds), .phase_err_in(pe), .overtemp_in(ot), .hs_gate(hg),
    .ls_gate(lg), .desat_fault(df), .phase_fault(pf), .overtemp_warn(ow),
    .blank_active(ba), .full_conduct_mode(fm), .zero_deadtime(zd),
    .deadtime(dt));
  tgc_spi_master i_m (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
  task wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo(input int c, input int lim);
    if (c >= lim) begin
      n_errors++;
      $display("Error %0t: timeout", $time);
      wrap_up;
    end
  endtask
  task w(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task cmd(input logic [3:0] op, input logic [11:0] d);
    i_m.xfer({op, d}, rx);
    w(12);
  endtask
  task rise(output int c);
    hs[0] = 1'b1;
    for (c = 0; c < 50 && hg[0] !== 1'b1; c++) begin
      @(posedge core_clk);
      #1;
    end
    tmo(c, 50);
    // back to a falling edge so the caller drives inputs off the sample
    w(1);
  endtask
  // cycles from high-side off to low-side on, phase 0
  task gap(output int gp);
    int a, c;
    a = 0;
    hs[0] = 1'b0;
    ls[0] = 1'b1;
    for (c = 1; c < 400 && lg[0] !== 1'b1; c++) begin
      @(posedge core_clk);
      #1;
      if (hg[0] === 1'b0 && a == 0) a = c;
    end
    tmo(c, 400);
    w(1);
    gp = c - 1 - a;
  endtask
  task t_spi;
    logic [11:0] di [4];
    logic [7:0] de [4];
    di = '{12'h064, 12'h000, 12'h0ff, 12'hfff};
    de = '{8'h64, 8'h01, 8'hff, 8'hff};
    for (int i = 0; i < 4; i++) begin
      cmd(tgc_pkg::CMD_DEADTIME, di[i]);
      chk({8'h00, dt}, {8'h00, de[i]});
    end
    cmd(tgc_pkg::CMD_NOP, 12'h000);
    chk(rx, 16'h007f);
    chk({15'h0, so_oe}, 16'h0000);
    cmd(tgc_pkg::CMD_ZERO_DT, 12'h000);
    chk({15'h0, zd}, 16'h0001);
    cmd(tgc_pkg::CMD_DEADTIME, 12'h014);
    chk({7'h0, zd, dt}, 16'h0014);
    $display("t_spi done");
  endtask
  task t_lat;
    rise(cn);
    chk({15'h0, cn >= 5 && cn <= 7}, 16'h0001);
    hs[0] = 1'b0;
    w(60);
    cmd(tgc_pkg::CMD_MODE, 12'h001);
    rise(cf);
    chk(16'(cn - cf), 16'h0001);
    ls[0] = 1'b1;
    w(12);
    chk({14'h0, hg[0], lg[0]}, 16'h0003);
    hs[0] = 1'b0;
    ls[0] = 1'b0;
    w(20);
    cmd(tgc_pkg::CMD_MODE, 12'h000);
    chk({15'h0, fm}, 16'h0000);
    $display("t_lat done");
  endtask
  task t_dt;
    hs[0] = 1'b1;
    w(60);
    gap(g);
    chk({15'h0, g >= 20 && g <= 22}, 16'h0001);
    ls[0] = 1'b0;
    w(60);
    cmd(tgc_pkg::CMD_ZERO_DT, 12'h000);
    hs[0] = 1'b1;
    w(40);
    gap(g);
    chk({15'h0, g <= 1}, 16'h0001);
    ls[0] = 1'b0;
    cmd(tgc_pkg::CMD_DEADTIME, 12'h014);
    // a second turn-off 12 cycles into the count restarts the full delay
    hs[0] = 1'b1;
    w(60);
    hs[0] = 1'b0;
    w(8);
    ls[0] = 1'b1;
    w(4);
    ls[0] = 1'b0;
    w(4);
    rise(g);
    chk({15'h0, g >= 22 && g <= 24}, 16'h0001);
    hs[0] = 1'b0;
    $display("t_dt done");
  endtask
  task t_blank;
    w(900);
    ds[0] = 1'b1;
    hs[1] = 1'b1;
    for (n = 0; n < 30 && ba !== 1'b1; n++) w(1);
    tmo(n, 30);
    for (n = 0; n < 1000 && ba === 1'b1; n++) w(1);
    tmo(n, 1000);
    chk(16'(n), 16'(tgc_pkg::BLANK_CYC));
    chk({13'h0, df}, 16'h0000);
    w(100);
    chk({13'h0, df}, 16'h0000);
    w(30);
    chk({13'h0, df}, 16'h0001);
    chk({15'h0, hg[1]}, 16'h0001);
    ds[0] = 1'b0;
    hs[1] = 1'b0;
    pe[2] = 1'b1;
    w(3);
    pe[2] = 1'b0;
    w(10);
    chk({13'h0, pf}, 16'h0004);
    cmd(tgc_pkg::CMD_CLEAR, 12'h000);
    chk({10'h0, df, pf}, 16'h0000);
    $display("t_blank done");
  endtask
  task t_ot;
    ot = 1'b1;
    w(100);
    chk({15'h0, ow}, 16'h0000);
    w(60);
    chk({15'h0, ow}, 16'h0001);
    ot = 1'b0;
    w(8);
    chk({15'h0, ow}, 16'h0000);
    $display("t_ot done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    n_errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    {hs, ls, ds, pe, ot} = 13'h0;
    w(12);
    chk({dt, hg, lg, so_oe, ba}, 16'h1000);
    reset_n = 1'b1;
    w(2);
    t_spi;
    t_lat;
    t_dt;
    t_blank;
    t_ot;
    wrap_up;
  end
endmodule
